// file: rtl/etm_compare_top.sv
// enhanced timer with two compare channels and period comparator, wishbone slave
// Function
// - mode field picks compare, capture, pwm, timer
// - compare match: keep, low, high, toggle pin
// - pwm: inactive, active, pwm, pwm
// - capture rising, falling, both, or disabled
// - no change when requested equals initial level
// - on bit rise restores initial pin level
// - output control sets initial or active level
// - polarity bit inverts output pins
// - alignment: edge, centre up, down, both
// - counter readable as low and high byte
// - high byte upper six bits read zero
// - ten-bit writable compare values a and b
// - compare mode clears on overflow, a, p
// - clear-select low: clear on p, flags a,p
// - clear-select high: clear on a, no p flag
// - only a or b match moves pins
// - period field compares counter bits nine to seven
// - on rise zeroes counter, off holds value
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module etm_compare_top
	import etm_pkg::*;
#(
	parameter int PRESCALE = 4
)(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W+1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic chan_a_pin_in,
	output logic chan_a_pin,
	output logic chan_a_pin_oe,
	input wire logic chan_b_pin_in,
	output logic chan_b_pin,
	output logic chan_b_pin_oe,
	output logic count_down
);
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl_a_q;
	logic [7:0] ctrl_b_q;
	logic [CNT_W-1:0] cmp_a_q;
	logic [CNT_W-1:0] cmp_b_q;
	logic [CNT_W-1:0] cnt_q;
	logic [2:0] flags_q;
	logic [31:0] rdata_q;
	logic ack_q;
	logic on_q;
	logic dir_q;
	logic [7:0] pre_q;
	logic tick;
	logic on_rise;
	logic running;
	logic match_a;
	logic match_b;
	logic match_p;
	logic top_hit;
	logic clear_cnt;
	logic set_a;
	logic set_b;
	logic set_p;
	logic pwm_a;
	logic pwm_b;
	logic cap_a;
	logic cap_b;
	logic wr;
	logic [2:0] clr_req;
	mode_t mode_a;
	mode_t mode_b;
	logic centre;
	assign mode_a = mode_t'(ctrl_a_q[CC_MODE_HI:CC_MODE_LO]);
	assign mode_b = mode_t'(ctrl_b_q[CC_MODE_HI:CC_MODE_LO]);
	assign running = ctrl0_q[C0_ON];
	assign on_rise = running & ~on_q;
	assign centre = (mode_b == MODE_PWM) && (ctrl_b_q[1:0] != ALIGN_EDGE);
	assign count_down = dir_q;

	function automatic logic [7:0] byte_of(input logic [31:0] d);
		byte_of = d[7:0];
	endfunction

	// wishbone: one wait state, ack pulses for one cycle
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end
	assign wb_ack_o = ack_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_q <= RST_BYTE;
			ctrl_a_q <= RST_BYTE;
			ctrl_b_q <= RST_BYTE;
			cmp_a_q <= '0;
			cmp_b_q <= '0;
		end else if (wr) begin
			if (wb_adr_i == ADR_CTRL0) begin
				ctrl0_q <= byte_of(wb_dat_i);
			end else if (wb_adr_i == ADR_CTRL_A) begin
				ctrl_a_q <= byte_of(wb_dat_i);
			end else if (wb_adr_i == ADR_CTRL_B) begin
				ctrl_b_q <= byte_of(wb_dat_i);
			end else if (wb_adr_i == ADR_CMPA_LO) begin
				cmp_a_q[7:0] <= byte_of(wb_dat_i);
			end else if (wb_adr_i == ADR_CMPA_HI) begin
				cmp_a_q[CNT_W-1:8] <= wb_dat_i[1:0];
			end else if (wb_adr_i == ADR_CMPB_LO) begin
				cmp_b_q[7:0] <= byte_of(wb_dat_i);
			end else if (wb_adr_i == ADR_CMPB_HI) begin
				cmp_b_q[CNT_W-1:8] <= wb_dat_i[1:0];
			end
		end
	end

	// reads: unmapped addresses return zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= '0;
			if (wb_adr_i == ADR_CTRL0) begin
				rdata_q[7:0] <= ctrl0_q;
			end else if (wb_adr_i == ADR_CTRL_A) begin
				rdata_q[7:0] <= {ctrl_a_q[7:2], dir_q, ctrl_a_q[0]};
			end else if (wb_adr_i == ADR_CTRL_B) begin
				rdata_q[7:0] <= ctrl_b_q;
			end else if (wb_adr_i == ADR_CNT_LO) begin
				rdata_q[7:0] <= cnt_q[7:0];
			end else if (wb_adr_i == ADR_CNT_HI) begin
				rdata_q[1:0] <= cnt_q[CNT_W-1:8];
			end else if (wb_adr_i == ADR_CMPA_LO) begin
				rdata_q[7:0] <= cmp_a_q[7:0];
			end else if (wb_adr_i == ADR_CMPA_HI) begin
				rdata_q[1:0] <= cmp_a_q[CNT_W-1:8];
			end else if (wb_adr_i == ADR_CMPB_LO) begin
				rdata_q[7:0] <= cmp_b_q[7:0];
			end else if (wb_adr_i == ADR_CMPB_HI) begin
				rdata_q[1:0] <= cmp_b_q[CNT_W-1:8];
			end else if (wb_adr_i == ADR_FLAGS) begin
				rdata_q[2:0] <= flags_q;
			end
		end
	end
	assign wb_dat_o = rdata_q;

	// timer clock enable divider; a plain divider stands in for the clock selector
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= '0;
		end else if (!running || pre_q == 8'(PRESCALE - 1)) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end
	assign tick = running && pre_q == 8'(PRESCALE - 1);

	// matches are judged on the current count at each tick
	assign match_a = tick && cnt_q == cmp_a_q;
	assign match_b = tick && cnt_q == cmp_b_q;
	assign match_p = tick && ((ctrl0_q[C0_PER_HI:0] == PER_OVF) ? (&cnt_q) :
		(cnt_q[PER_MSB:PER_LSB] == ctrl0_q[C0_PER_HI:0] && cnt_q[PER_LSB-1:0] == '0));
	assign top_hit = ctrl_a_q[CC_CLR] ? match_a : match_p;
	assign clear_cnt = !centre && top_hit;
	assign set_a = match_a;
	assign set_b = match_b;
	assign set_p = match_p && !ctrl_a_q[CC_CLR];

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			on_q <= 1'b0;
		end else begin
			on_q <= running;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			dir_q <= 1'b0;
		end else if (on_rise) begin
			cnt_q <= '0;
			dir_q <= 1'b0;
		end else if (tick) begin
			if (centre && !dir_q && top_hit) begin
				dir_q <= 1'b1;
				cnt_q <= cnt_q - 10'h001;
			end else if (centre && dir_q) begin
				dir_q <= (cnt_q != '0) && (cnt_q != 10'h001);
				cnt_q <= cnt_q - 10'h001;
			end else if (clear_cnt) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 10'h001;
			end
		end
	end

	// sticky flags, write one to clear; a new event wins over the clear
	assign clr_req = (wr && wb_adr_i == ADR_FLAGS) ? wb_dat_i[2:0] : 3'h0;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~clr_req) | {set_p, set_b, set_a};
		end
	end

	// pwm compare: alignment picks which direction a match counts
	function automatic logic pwm_level(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] d,
		input logic [1:0] al, input logic dn);
		logic r;
		r = c < d;
		if (al == ALIGN_UP && dn) begin
			r = 1'b1;
		end else if (al == ALIGN_DOWN && !dn) begin
			r = 1'b0;
		end
		pwm_level = r;
	endfunction
	assign pwm_a = pwm_level(cnt_q, cmp_a_q, ctrl_b_q[1:0], dir_q);
	assign pwm_b = pwm_level(cnt_q, cmp_b_q, ctrl_b_q[1:0], dir_q);

	etm_pin_channel u_chan_a (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.mode(ctrl_a_q[CC_MODE_HI:CC_MODE_LO]),
		.pin_function(ctrl_a_q[CC_IO_HI:CC_IO_LO]),
		.output_control(ctrl_a_q[CC_OC]),
		.polarity(ctrl_a_q[CC_POL]),
		.on_rise(on_rise),
		.match(set_a),
		.pwm_active(pwm_a),
		.pin_in(chan_a_pin_in),
		.pin_out(chan_a_pin),
		.pin_oe(chan_a_pin_oe),
		.capture(cap_a)
	);
	etm_pin_channel u_chan_b (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.mode(ctrl_b_q[CC_MODE_HI:CC_MODE_LO]),
		.pin_function(ctrl_b_q[CC_IO_HI:CC_IO_LO]),
		.output_control(ctrl_b_q[CC_OC]),
		.polarity(ctrl_b_q[CC_POL]),
		.on_rise(on_rise),
		.match(set_b),
		.pwm_active(pwm_b),
		.pin_in(chan_b_pin_in),
		.pin_out(chan_b_pin),
		.pin_oe(chan_b_pin_oe),
		.capture(cap_b)
	);

	// captures latch the counter into cap_val_q, which no register reads back
	logic [CNT_W-1:0] cap_val_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_val_q <= '0;
		end else if (cap_a | cap_b) begin
			cap_val_q <= cnt_q;
		end
	end

	chk_on_zero: assert property (@(posedge core_clk) disable iff (!rst_b) on_rise |=> cnt_q == '0)
		else $error("counter not zero after on");
	chk_off_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!running && on_q |=> $stable(cnt_q))
		else $error("counter moved while off");
	chk_no_pflag: assert property (@(posedge core_clk) disable iff (!rst_b)
		ctrl_a_q[CC_CLR] && !flags_q[FL_P] && !(wr && wb_adr_i == ADR_FLAGS) |=> !flags_q[FL_P])
		else $error("period flag with clear select high");
	chk_a_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		match_a && ctrl_a_q[CC_CLR] && !centre && !on_rise |=> cnt_q == '0)
		else $error("counter not cleared on a match");
	chk_p_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		match_p && !ctrl_a_q[CC_CLR] && !centre && !on_rise |=> cnt_q == '0 && flags_q[FL_P])
		else $error("period match did not clear");
	chk_a_flag: assert property (@(posedge core_clk) disable iff (!rst_b) match_a |=> flags_q[FL_A])
		else $error("a flag missing");
	chk_pin_init: assert property (@(posedge core_clk) disable iff (!rst_b)
		on_rise && mode_b == MODE_CMP |=> chan_b_pin == (ctrl_b_q[CC_OC] ^ ctrl_b_q[CC_POL]))
		else $error("pin b not at initial level");
	chk_pin_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode_b == MODE_CMP && !match_b && !on_rise |=> $stable(chan_b_pin) || !$stable(ctrl_b_q))
		else $error("pin b moved without match");
	chk_tmr_oe: assert property (@(posedge core_clk) disable iff (!rst_b) mode_b == MODE_TMR |-> !chan_b_pin_oe)
		else $error("pin driven in timer mode");
	chk_hi_zero: assert property (@(posedge core_clk) disable iff (!rst_b) wb_ack_o |-> wb_dat_o[31:8] == '0)
		else $error("upper read bits not zero");
endmodule

// file: rtl/etm_pin_channel.sv
// one compare/capture channel output stage
`timescale 1ns/10ps
module etm_pin_channel
	import etm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [1:0] mode,
	input wire logic [1:0] pin_function,
	input wire logic output_control,
	input wire logic polarity,
	input wire logic on_rise,
	input wire logic match,
	input wire logic pwm_active,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic capture
);
	logic level_q;
	logic level_d;
	logic pin_in_q;
	logic raw;
	always_comb begin
		level_d = level_q;
		if (on_rise) begin
			level_d = output_control;
		end else if (match && mode == MODE_CMP) begin
			case (pin_function)
				IO_LOW: level_d = 1'b0;
				IO_HIGH: level_d = 1'b1;
				IO_TOGGLE: level_d = ~level_q;
				default: level_d = level_q;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= 1'b0;
			pin_in_q <= 1'b0;
		end else begin
			level_q <= level_d;
			pin_in_q <= pin_in;
		end
	end
	// pwm levels: active level set by output control
	always_comb begin
		raw = level_q;
		if (mode == MODE_PWM) begin
			case (pin_function)
				IO_KEEP: raw = ~output_control;
				IO_LOW: raw = output_control;
				default: raw = pwm_active ? output_control : ~output_control;
			endcase
		end
	end
	assign pin_out = raw ^ polarity;
	assign pin_oe = (mode == MODE_CMP) || (mode == MODE_PWM);
	always_comb begin
		case (pin_function)
			2'b00: capture = pin_in & ~pin_in_q;
			2'b01: capture = ~pin_in & pin_in_q;
			2'b10: capture = pin_in ^ pin_in_q;
			default: capture = 1'b0;
		endcase
		if (mode != MODE_CAP) begin
			capture = 1'b0;
		end
	end
endmodule

// file: rtl/etm_pkg.sv
// shared constants for the enhanced timer compare block
package etm_pkg;
	localparam int CNT_W = 10;
	localparam int ADR_W = 4;
	// register word offsets (byte addresses)
	localparam logic [ADR_W+1:0] ADR_CTRL0 = 6'h00;
	localparam logic [ADR_W+1:0] ADR_CTRL_A = 6'h04;
	localparam logic [ADR_W+1:0] ADR_CTRL_B = 6'h08;
	localparam logic [ADR_W+1:0] ADR_CNT_LO = 6'h0C;
	localparam logic [ADR_W+1:0] ADR_CNT_HI = 6'h10;
	localparam logic [ADR_W+1:0] ADR_CMPA_LO = 6'h14;
	localparam logic [ADR_W+1:0] ADR_CMPA_HI = 6'h18;
	localparam logic [ADR_W+1:0] ADR_CMPB_LO = 6'h1C;
	localparam logic [ADR_W+1:0] ADR_CMPB_HI = 6'h20;
	localparam logic [ADR_W+1:0] ADR_FLAGS = 6'h24;
	// control 0 fields
	localparam int C0_ON = 3;
	localparam int C0_PER_HI = 2;
	// channel control fields (same layout for A and B, except CC_CLR, which only A uses; B bits 1:0 are alignment)
	localparam int CC_MODE_HI = 7;
	localparam int CC_MODE_LO = 6;
	localparam int CC_IO_HI = 5;
	localparam int CC_IO_LO = 4;
	localparam int CC_OC = 3;
	localparam int CC_POL = 2;
	localparam int CC_CLR = 0;
	// flag bits
	localparam int FL_A = 0;
	localparam int FL_B = 1;
	localparam int FL_P = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] PER_OVF = 3'h0;
	localparam int PER_MSB = 9;
	localparam int PER_LSB = 7;
	typedef enum logic [1:0] {
		MODE_CMP = 2'b00,
		MODE_CAP = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TMR = 2'b11
	} mode_t;
	typedef enum logic [1:0] {
		IO_KEEP = 2'b00,
		IO_LOW = 2'b01,
		IO_HIGH = 2'b10,
		IO_TOGGLE = 2'b11
	} io_t;
	localparam logic [1:0] ALIGN_EDGE = 2'b00;
	localparam logic [1:0] ALIGN_UP = 2'b01;
	localparam logic [1:0] ALIGN_DOWN = 2'b10;
	localparam logic [1:0] ALIGN_BOTH = 2'b11;
endpackage

// file: tb/enhanced_timer_compare_channels_tb.sv
// self-checking bench for the timer compare block
`timescale 1ns/10ps
module enhanced_timer_compare_channels_tb;
	import etm_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic req = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, a_pin, a_oe, a_in, b_pin, b_oe, b_in, dn;
	int error_cnt = 0;
	int checks = 0;
	int cyc_cnt = 0;
	always #12.5 core_clk = ~core_clk;
	// prescale of one keeps the compare waits short
	etm_compare_top #(.PRESCALE(1)) uut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chan_a_pin_in(a_in), .chan_a_pin(a_pin), .chan_a_pin_oe(a_oe), .chan_b_pin_in(b_in), .chan_b_pin(b_pin),
		.chan_b_pin_oe(b_oe), .count_down(dn));
	etm_pin_load load (.chan_a_pin(a_pin), .chan_a_pin_oe(a_oe), .chan_b_pin(b_pin), .chan_b_pin_oe(b_oe),
		.chan_a_pin_in(a_in), .chan_b_pin_in(b_in));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// one classic cycle: request held until ack is sampled high, released at that edge
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		// ack is looked at mid-cycle, where it has settled; the next rising edge is the one that samples it
		do begin
			@(negedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		r = wb_dat_o[7:0];
		@(posedge core_clk);
		req <= 1'b0;
		if (n >= 20) chk("bus ack", 8'h01, 8'h00);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] r;
		wb(1'b0, a, 8'h00, r);
		chk($sformatf("reg %h", a), e, r);
	endtask
	task automatic pin_chk(input string s, input logic e, input logic g);
		chk(s, {7'h0, e}, {7'h0, g});
	endtask
	task automatic t_reset();
		logic [5:0] al [8] = '{ADR_CTRL_B, ADR_CNT_LO, ADR_CNT_HI, ADR_CMPA_LO, ADR_CMPA_HI, ADR_CMPB_LO,
			ADR_CMPB_HI, 6'h3C};
		foreach (al[i]) rd_chk(al[i], RST_BYTE);
	endtask
	task automatic t_regs();
		wr(ADR_CMPB_HI, 8'hFF);
		rd_chk(ADR_CMPB_HI, 8'h03);
		wr(ADR_CMPB_LO, 8'hA5);
		rd_chk(ADR_CMPB_LO, 8'hA5);
		wr(ADR_CMPA_HI, 8'hFE);
		rd_chk(ADR_CMPA_HI, 8'h02);
		wr(ADR_CNT_LO, 8'hFF);
		rd_chk(ADR_CNT_LO, 8'h00);
	endtask
	// a clears at 200, b matches at 10, period 128 lies below a
	task automatic t_compare();
		logic [1:0] io;
		logic oc, pol, lvl;
		wr(ADR_CMPA_LO, 8'hC8);
		wr(ADR_CMPA_HI, 8'h00);
		wr(ADR_CMPB_LO, 8'h0A);
		wr(ADR_CMPB_HI, 8'h00);
		wr(ADR_CTRL_A, 8'h01);
		for (int k = 0; k < 16; k++) begin
			{io, oc, pol} = k[3:0];
			wr(ADR_CTRL0, 8'h01);
			wr(ADR_CTRL_B, {2'b00, io, oc, pol, 2'b00});
			wr(ADR_CTRL0, 8'h09);
			repeat (5) @(posedge core_clk);
			pin_chk("initial pin", oc ^ pol, b_pin);
			repeat (25) @(posedge core_clk);
			lvl = (io == IO_KEEP) ? oc : (io == IO_LOW) ? 1'b0 : (io == IO_HIGH) ? 1'b1 : ~oc;
			pin_chk("match pin", lvl ^ pol, b_pin);
		end
		repeat (250) @(posedge core_clk);
		rd_chk(ADR_FLAGS, 8'h03);
	endtask
	task automatic t_period();
		logic [7:0] r;
		wr(ADR_CTRL0, 8'h01);
		wr(ADR_CMPA_LO, 8'h32);
		wr(ADR_CTRL_A, 8'h00);
		wr(ADR_FLAGS, 8'h07);
		wr(ADR_CTRL0, 8'h09);
		repeat (300) @(posedge core_clk);
		rd_chk(ADR_FLAGS, 8'h07);
		// without the clear at 128 the count would pass 255 here
		repeat (4) begin
			repeat (37) @(posedge core_clk);
			rd_chk(ADR_CNT_HI, 8'h00);
		end
		wr(ADR_CTRL0, 8'h01);
		wb(1'b0, ADR_CNT_LO, 8'h00, r);
		repeat (20) @(posedge core_clk);
		rd_chk(ADR_CNT_LO, r);
		wr(ADR_CTRL0, 8'h09);
		wb(1'b0, ADR_CNT_LO, 8'h00, r);
		chk("count after on", 8'h01, {7'h0, r < 8'h08});
	endtask
	task automatic t_modes();
		wr(ADR_CTRL0, 8'h00);
		wr(ADR_CTRL_A, 8'h80);
		for (int k = 0; k < 4; k++) begin
			wr(ADR_CTRL_B, {3'b100, k[1], k[0], 3'b000});
			wr(ADR_CTRL0, 8'h09);
			repeat (5) @(posedge core_clk);
			pin_chk("forced pwm pin", k[1] ? k[0] : ~k[0], b_pin);
			pin_chk("pwm drive", 1'b1, b_oe);
			wr(ADR_CTRL0, 8'h00);
		end
		// centre aligned: counts up to the 128 period, then back down
		wr(ADR_CTRL_B, 8'h81);
		wr(ADR_CTRL0, 8'h09);
		repeat (20) @(posedge core_clk);
		pin_chk("centre count up", 1'b0, dn);
		repeat (130) @(posedge core_clk);
		pin_chk("centre count down", 1'b1, dn);
		wr(ADR_CTRL0, 8'h00);
		wr(ADR_CTRL_A, 8'hC0);
		wr(ADR_CTRL_B, 8'hC0);
		repeat (2) @(posedge core_clk);
		pin_chk("timer mode drive", 1'b0, b_oe);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_regs();
		t_compare();
		t_period();
		t_modes();
		end_of_test();
	end
endmodule

// file: tb/etm_pin_load.sv
// external load on the two timer pins, feeding the sensed wire level back
`timescale 1ns/10ps
module etm_pin_load (
	input wire logic chan_a_pin,
	input wire logic chan_a_pin_oe,
	input wire logic chan_b_pin,
	input wire logic chan_b_pin_oe,
	output logic chan_a_pin_in,
	output logic chan_b_pin_in
);
	// pull-down on each pin: a released pin reads low, never the last driven value
	assign chan_a_pin_in = chan_a_pin_oe ? chan_a_pin : 1'b0;
	assign chan_b_pin_in = chan_b_pin_oe ? chan_b_pin : 1'b0;
endmodule
